// *** hdl/iaa_pkg.sv ***
// package: register map, modes, field layouts and constants of the adjust controller
package iaa_pkg;
	localparam int CW = 12;
	localparam int PW = 16;
	localparam int NREG = 2;
	// register offsets
	localparam logic [7:0] A_MODE = 8'h00;
	localparam logic [7:0] A_RSEL = 8'h04;
	localparam logic [7:0] A_RUSE = 8'h08;
	localparam logic [7:0] A_RXOF = 8'h0C;
	localparam logic [7:0] A_RWID = 8'h10;
	localparam logic [7:0] A_RYOF = 8'h14;
	localparam logic [7:0] A_RHGT = 8'h18;
	localparam logic [7:0] A_WXOF = 8'h1C;
	localparam logic [7:0] A_WWID = 8'h20;
	localparam logic [7:0] A_WYOF = 8'h24;
	localparam logic [7:0] A_WHGT = 8'h28;
	localparam logic [7:0] A_TGT = 8'h2C;
	localparam logic [7:0] A_GLIM = 8'h30;
	localparam logic [7:0] A_ELIM = 8'h34;
	localparam logic [7:0] A_GAIN = 8'h38;
	localparam logic [7:0] A_EXPO = 8'h3C;
	localparam logic [7:0] A_BAL = 8'h40;
	localparam logic [7:0] A_STAT = 8'h44;
	// field positions in the mode register
	localparam int F_GAIN = 0;
	localparam int F_EXPO = 2;
	localparam int F_BAL = 4;
	localparam int F_SEQ = 8;
	localparam int F_FACT = 9;
	localparam int F_HALF = 10;
	// mode encoding
	localparam logic [1:0] M_OFF = 2'h0;
	localparam logic [1:0] M_ONCE = 2'h1;
	localparam logic [1:0] M_CONT = 2'h2;
	localparam logic [4:0] ONCE_MAX = 5'h1E;
	localparam logic [1:0] START_DELAY = 2'h2;
	localparam logic [PW-1:0] STEP = 16'h0001;
	localparam logic [PW-1:0] TOL = 16'h0002;
	localparam logic [PW-1:0] TGT_RST = 16'h0080;
	localparam logic [PW-1:0] PAR_RST = 16'h0100;
	localparam logic [PW-1:0] LIM_HI_RST = 16'hFFFF;
	localparam logic [CW-1:0] SENS_W = 12'h400;
	localparam logic [CW-1:0] SENS_H = 12'h400;
	// a rectangle on the sensor
	typedef struct packed {
		logic [CW-1:0] xo;
		logic [CW-1:0] w;
		logic [CW-1:0] yo;
		logic [CW-1:0] h;
	} iaa_rect_s;
	// one pixel from the binned pipeline
	typedef struct packed {
		logic valid;
		logic [CW-1:0] col;
		logic [CW-1:0] row;
		logic [7:0] luma;
		logic [7:0] red;
		logic [7:0] blue;
	} iaa_pix_s;
endpackage : iaa_pkg

// *** hdl/iaa_ctrl.sv ***
// file: top of the per-frame automatic gain, exposure and colour balance controller
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - all functions off after reset
// - factory startup set enables exposure automatically
// - sequencer enabled freezes all automatic functions
// - manual writes ignored while function adjusts
// - keep parameter within lower and upper limits
// - unreachable target: approach as close possible
// - statistics taken from binned pixel stream
// - single-shot stops itself when target reached
// - single-shot gives up after 30 images
// - repeating adjusts every or every second image
// - off keeps last automatic value in force
// - modes changeable live, short start delay
// - region is offsets and sizes from origin
// - regions independent of output window, anywhere
// - use pixels in region and window only
// - default: brightness region 1, balance region 2
// - gain and exposure share region flag, separate modes
// - all functions may run together
// - no overlap keeps gain at manual value
// - gain driven until region average meets target
module iaa_ctrl #(
	parameter int NR = iaa_pkg::NREG
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic factory_start_i,
	input wire logic frame_end_i,
	input wire iaa_pkg::iaa_pix_s pix_i,
	output logic [15:0] gain_o,
	output logic [15:0] expo_o,
	output logic [15:0] bal_o
);
	localparam int CW = iaa_pkg::CW;
	localparam int PW = iaa_pkg::PW;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} iaa_st_e;

	// inside test for one rectangle, used for every region and the window
	function automatic logic in_rect(input iaa_pkg::iaa_rect_s r,
		input logic [CW-1:0] c, input logic [CW-1:0] y);
		in_rect = (c >= r.xo) && (c < r.xo + r.w) &&
			(y >= r.yo) && (y < r.yo + r.h);
	endfunction : in_rect

	// one control step toward target, clamped to the limits
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p,
		input logic [PW-1:0] avg, input logic [PW-1:0] tgt,
		input logic [PW-1:0] lo, input logic [PW-1:0] hi);
		logic [PW-1:0] q;
		q = p;
		if (avg + iaa_pkg::TOL < tgt && p < hi)
			q = p + iaa_pkg::STEP;
		else if (avg > tgt + iaa_pkg::TOL && p > lo)
			q = p - iaa_pkg::STEP;
		if (q > hi)
			q = hi;
		if (q < lo)
			q = lo;
		step = q;
	endfunction : step

	function automatic logic near(input logic [PW-1:0] avg,
		input logic [PW-1:0] tgt);
		near = (avg + iaa_pkg::TOL >= tgt) && (avg <= tgt + iaa_pkg::TOL);
	endfunction : near

	// registers
	logic [1:0] mode_r [3], mode_nxt [3];
	logic seq_r, seq_nxt, half_r, half_nxt;
	logic [0:0] rsel_r, rsel_nxt;
	logic use_b_r [NR], use_b_nxt [NR], use_c_r [NR], use_c_nxt [NR];
	iaa_pkg::iaa_rect_s reg_r [NR], reg_nxt [NR];
	iaa_pkg::iaa_rect_s win_r, win_nxt;
	logic [PW-1:0] tgt_r, tgt_nxt;
	logic [PW-1:0] glo_r, glo_nxt, ghi_r, ghi_nxt;
	logic [PW-1:0] elo_r, elo_nxt, ehi_r, ehi_nxt;
	logic [PW-1:0] par_r [3], par_nxt [3];
	logic [31:0] rdata_nxt;
	// per-frame statistics
	logic [31:0] sb_r, sb_nxt, sr_r, sr_nxt, su_r, su_nxt;
	logic [23:0] nb_r, nb_nxt, nc_r, nc_nxt;
	logic [PW-1:0] avgb, avgc;
	// per-function sequencing
	iaa_st_e st_r [3], st_nxt [3];
	logic [1:0] dly_r [3], dly_nxt [3];
	logic [4:0] cnt_r [3], cnt_nxt [3];
	logic skip_r, skip_nxt;
	logic boot_r, boot_nxt;
	logic in_b, in_c, hit;

	// pixel classification: region membership and output window together
	always_comb begin
		in_b = 1'b0;
		in_c = 1'b0;
		hit = pix_i.valid && in_rect(win_r, pix_i.col, pix_i.row);
		for (int i = 0; i < NR; i++) begin
			if (use_b_r[i] && in_rect(reg_r[i], pix_i.col, pix_i.row))
				in_b = 1'b1;
			if (use_c_r[i] && in_rect(reg_r[i], pix_i.col, pix_i.row))
				in_c = 1'b1;
		end
		in_b = in_b && hit;
		in_c = in_c && hit;
	end

	// averages come from a combinational divider on the running sums every cycle; cost traded for simplicity
	always_comb begin
		avgb = (nb_r == 24'h00_0000) ? '0 : PW'(sb_r / 32'(nb_r));
		avgc = (nc_r == 24'h00_0000) ? '0 : PW'(sr_r / 32'(nc_r));
	end

	// accumulate binned luma and colour sums over the frame
	always_comb begin
		sb_nxt = sb_r;
		sr_nxt = sr_r;
		su_nxt = su_r;
		nb_nxt = nb_r;
		nc_nxt = nc_r;
		if (frame_end_i) begin
			sb_nxt = '0;
			sr_nxt = '0;
			su_nxt = '0;
			nb_nxt = '0;
			nc_nxt = '0;
		end else begin
			if (in_b) begin
				sb_nxt = sb_r + 32'(pix_i.luma);
				nb_nxt = nb_r + 24'h00_0001;
			end
			if (in_c) begin
				// red minus blue offset around the target midpoint
				sr_nxt = sr_r + 32'(pix_i.red) + 32'h0000_0080 - 32'(pix_i.blue);
				su_nxt = su_r + 32'(pix_i.blue);
				nc_nxt = nc_r + 24'h00_0001;
			end
		end
	end

	// function sequencing, bus writes and parameter updates
	always_comb begin
		logic [PW-1:0] lo, hi, avg;
		logic cnt_ok, adj;
		lo = '0;
		hi = '0;
		avg = '0;
		cnt_ok = 1'b0;
		adj = 1'b0;
		seq_nxt = seq_r;
		half_nxt = half_r;
		rsel_nxt = rsel_r;
		win_nxt = win_r;
		tgt_nxt = tgt_r;
		glo_nxt = glo_r;
		ghi_nxt = ghi_r;
		elo_nxt = elo_r;
		ehi_nxt = ehi_r;
		skip_nxt = skip_r;
		boot_nxt = 1'b0;
		for (int i = 0; i < NR; i++) begin
			use_b_nxt[i] = use_b_r[i];
			use_c_nxt[i] = use_c_r[i];
			reg_nxt[i] = reg_r[i];
		end
		for (int f = 0; f < 3; f++) begin
			mode_nxt[f] = mode_r[f];
			par_nxt[f] = par_r[f];
			st_nxt[f] = st_r[f];
			dly_nxt[f] = dly_r[f];
			cnt_nxt[f] = cnt_r[f];
		end
		// strapped startup set caught once after reset release
		if (boot_r && factory_start_i)
			mode_nxt[1] = iaa_pkg::M_CONT;
		if (wr_i) begin
			case (addr_i)
				iaa_pkg::A_MODE: begin
					mode_nxt[0] = wdata_i[iaa_pkg::F_GAIN +: 2];
					mode_nxt[1] = wdata_i[iaa_pkg::F_EXPO +: 2];
					mode_nxt[2] = wdata_i[iaa_pkg::F_BAL +: 2];
					seq_nxt = wdata_i[iaa_pkg::F_SEQ];
					half_nxt = wdata_i[iaa_pkg::F_HALF];
				end
				iaa_pkg::A_RSEL: rsel_nxt = wdata_i[0:0];
				iaa_pkg::A_RUSE: begin
					use_b_nxt[rsel_r] = wdata_i[0];
					use_c_nxt[rsel_r] = wdata_i[1];
				end
				iaa_pkg::A_RXOF: reg_nxt[rsel_r].xo = wdata_i[CW-1:0];
				iaa_pkg::A_RWID: reg_nxt[rsel_r].w = wdata_i[CW-1:0];
				iaa_pkg::A_RYOF: reg_nxt[rsel_r].yo = wdata_i[CW-1:0];
				iaa_pkg::A_RHGT: reg_nxt[rsel_r].h = wdata_i[CW-1:0];
				iaa_pkg::A_WXOF: win_nxt.xo = wdata_i[CW-1:0];
				iaa_pkg::A_WWID: win_nxt.w = wdata_i[CW-1:0];
				iaa_pkg::A_WYOF: win_nxt.yo = wdata_i[CW-1:0];
				iaa_pkg::A_WHGT: win_nxt.h = wdata_i[CW-1:0];
				iaa_pkg::A_TGT: tgt_nxt = wdata_i[PW-1:0];
				iaa_pkg::A_GLIM: begin
					glo_nxt = wdata_i[PW-1:0];
					ghi_nxt = wdata_i[31:PW];
				end
				iaa_pkg::A_ELIM: begin
					elo_nxt = wdata_i[PW-1:0];
					ehi_nxt = wdata_i[31:PW];
				end
				iaa_pkg::A_GAIN:
					if (st_r[0] == ST_IDLE && mode_r[0] == iaa_pkg::M_OFF)
						par_nxt[0] = wdata_i[PW-1:0];
				iaa_pkg::A_EXPO:
					if (st_r[1] == ST_IDLE && mode_r[1] == iaa_pkg::M_OFF)
						par_nxt[1] = wdata_i[PW-1:0];
				iaa_pkg::A_BAL:
					if (st_r[2] == ST_IDLE && mode_r[2] == iaa_pkg::M_OFF)
						par_nxt[2] = wdata_i[PW-1:0];
				default: ;
			endcase
		end
		if (frame_end_i) begin
			skip_nxt = half_r ? !skip_r : 1'b0;
			for (int f = 0; f < 3; f++) begin
				lo = (f == 0) ? glo_r : (f == 1) ? elo_r : '0;
				hi = (f == 0) ? ghi_r : (f == 1) ? ehi_r
					: iaa_pkg::LIM_HI_RST;
				avg = (f == 2) ? avgc : avgb;
				cnt_ok = (f == 2) ? (nc_r != 24'h00_0000)
					: (nb_r != 24'h00_0000);
				adj = 1'b0;
				case (st_r[f])
					ST_IDLE:
						if (mode_r[f] != iaa_pkg::M_OFF && !seq_r) begin
							st_nxt[f] = ST_WAIT;
							dly_nxt[f] = iaa_pkg::START_DELAY;
							cnt_nxt[f] = '0;
						end
					ST_WAIT:
						if (dly_r[f] == 2'h0)
							st_nxt[f] = ST_RUN;
						else
							dly_nxt[f] = dly_r[f] - 2'h1;
					ST_RUN:
						adj = !skip_r;
					default: st_nxt[f] = ST_IDLE;
				endcase
				// no pixels in the overlap leaves the parameter as set
				if (adj && cnt_ok)
					par_nxt[f] = step(par_r[f], avg,
						(f == 2) ? iaa_pkg::TGT_RST : tgt_r, lo, hi);
				if (st_r[f] == ST_RUN && mode_r[f] == iaa_pkg::M_ONCE) begin
					cnt_nxt[f] = cnt_r[f] + 5'h01;
					if ((cnt_ok && near(avg, (f == 2) ? iaa_pkg::TGT_RST : tgt_r))
						|| cnt_r[f] + 5'h01 >= iaa_pkg::ONCE_MAX) begin
						mode_nxt[f] = iaa_pkg::M_OFF;
						st_nxt[f] = ST_IDLE;
					end
				end
			end
		end
		// leaving a mode stops adjusting; last value stays in par_r
		for (int f = 0; f < 3; f++)
			if (mode_nxt[f] == iaa_pkg::M_OFF || seq_nxt)
				st_nxt[f] = ST_IDLE;
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_nxt = '0;
		if (rd_i) begin
			case (addr_i)
				iaa_pkg::A_MODE: begin
					rdata_nxt[iaa_pkg::F_GAIN +: 2] = mode_r[0];
					rdata_nxt[iaa_pkg::F_EXPO +: 2] = mode_r[1];
					rdata_nxt[iaa_pkg::F_BAL +: 2] = mode_r[2];
					rdata_nxt[iaa_pkg::F_SEQ] = seq_r;
					rdata_nxt[iaa_pkg::F_HALF] = half_r;
				end
				iaa_pkg::A_RSEL: rdata_nxt[0:0] = rsel_r;
				iaa_pkg::A_RUSE: rdata_nxt[1:0] = {use_c_r[rsel_r], use_b_r[rsel_r]};
				iaa_pkg::A_RXOF: rdata_nxt[CW-1:0] = reg_r[rsel_r].xo;
				iaa_pkg::A_RWID: rdata_nxt[CW-1:0] = reg_r[rsel_r].w;
				iaa_pkg::A_RYOF: rdata_nxt[CW-1:0] = reg_r[rsel_r].yo;
				iaa_pkg::A_RHGT: rdata_nxt[CW-1:0] = reg_r[rsel_r].h;
				iaa_pkg::A_WXOF: rdata_nxt[CW-1:0] = win_r.xo;
				iaa_pkg::A_WWID: rdata_nxt[CW-1:0] = win_r.w;
				iaa_pkg::A_WYOF: rdata_nxt[CW-1:0] = win_r.yo;
				iaa_pkg::A_WHGT: rdata_nxt[CW-1:0] = win_r.h;
				iaa_pkg::A_TGT: rdata_nxt[PW-1:0] = tgt_r;
				iaa_pkg::A_GLIM: rdata_nxt = {ghi_r, glo_r};
				iaa_pkg::A_ELIM: rdata_nxt = {ehi_r, elo_r};
				iaa_pkg::A_GAIN: rdata_nxt[PW-1:0] = par_r[0];
				iaa_pkg::A_EXPO: rdata_nxt[PW-1:0] = par_r[1];
				iaa_pkg::A_BAL: rdata_nxt[PW-1:0] = par_r[2];
				iaa_pkg::A_STAT: rdata_nxt[PW-1:0] = avgb;
				default: rdata_nxt = '0;
			endcase
		end
	end

	// register stage; reset defaults put everything off
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			seq_r <= 1'b0;
			half_r <= 1'b0;
			rsel_r <= '0;
			win_r <= '{xo: '0, w: iaa_pkg::SENS_W, yo: '0, h: iaa_pkg::SENS_H};
			tgt_r <= iaa_pkg::TGT_RST;
			glo_r <= '0;
			ghi_r <= iaa_pkg::LIM_HI_RST;
			elo_r <= '0;
			ehi_r <= iaa_pkg::LIM_HI_RST;
			skip_r <= 1'b0;
			boot_r <= 1'b1;
			rdata_o <= '0;
			sb_r <= '0;
			sr_r <= '0;
			su_r <= '0;
			nb_r <= '0;
			nc_r <= '0;
			for (int i = 0; i < NR; i++) begin
				use_b_r[i] <= (i == 0);
				use_c_r[i] <= (i == 1);
				reg_r[i] <= '{xo: '0, w: iaa_pkg::SENS_W, yo: '0, h: iaa_pkg::SENS_H};
			end
			for (int f = 0; f < 3; f++) begin
				mode_r[f] <= iaa_pkg::M_OFF;
				par_r[f] <= iaa_pkg::PAR_RST;
				st_r[f] <= ST_IDLE;
				dly_r[f] <= '0;
				cnt_r[f] <= '0;
			end
		end else begin
			seq_r <= seq_nxt;
			half_r <= half_nxt;
			rsel_r <= rsel_nxt;
			win_r <= win_nxt;
			tgt_r <= tgt_nxt;
			glo_r <= glo_nxt;
			ghi_r <= ghi_nxt;
			elo_r <= elo_nxt;
			ehi_r <= ehi_nxt;
			skip_r <= skip_nxt;
			boot_r <= boot_nxt;
			rdata_o <= rdata_nxt;
			sb_r <= sb_nxt;
			sr_r <= sr_nxt;
			su_r <= su_nxt;
			nb_r <= nb_nxt;
			nc_r <= nc_nxt;
			for (int i = 0; i < NR; i++) begin
				use_b_r[i] <= use_b_nxt[i];
				use_c_r[i] <= use_c_nxt[i];
				reg_r[i] <= reg_nxt[i];
			end
			for (int f = 0; f < 3; f++) begin
				mode_r[f] <= mode_nxt[f];
				par_r[f] <= par_nxt[f];
				st_r[f] <= st_nxt[f];
				dly_r[f] <= dly_nxt[f];
				cnt_r[f] <= cnt_nxt[f];
			end
		end
	end

	// applied parameters straight from their registers
	assign gain_o = par_r[0];
	assign expo_o = par_r[1];
	assign bal_o = par_r[2];
endmodule : iaa_ctrl
`default_nettype wire

// *** test/iaa_ctrl_chk.sv ***
// checker: port-level properties of the adjust controller
`timescale 1ns/1ps
`default_nettype none
module iaa_ctrl_chk (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic factory_start_i,
	input wire logic frame_end_i,
	input wire iaa_pkg::iaa_pix_s pix_i,
	input wire logic [15:0] gain_o,
	input wire logic [15:0] expo_o,
	input wire logic [15:0] bal_o
);
	logic seq_r, seq_nxt, goff_r, goff_nxt, mw;
	logic [31:0] glim_r, glim_nxt;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// shadow of what software last wrote; hardware once-clear is not tracked
	assign mw = wr_i && addr_i == iaa_pkg::A_MODE;
	always_comb begin
		seq_nxt = mw ? wdata_i[iaa_pkg::F_SEQ] : seq_r;
		goff_nxt = mw ? (wdata_i[1:0] == iaa_pkg::M_OFF) : goff_r;
		glim_nxt = (wr_i && addr_i == iaa_pkg::A_GLIM) ? wdata_i : glim_r;
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			seq_r <= 1'b0;
			goff_r <= 1'b1;
			glim_r <= 32'hFFFF_0000;
		end else begin
			seq_r <= seq_nxt;
			goff_r <= goff_nxt;
			glim_r <= glim_nxt;
		end
	end
	property p_rd_idle;
		!rd_i |=> rdata_o == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rst;
		disable iff (1'b0) rst_i |=> gain_o == iaa_pkg::PAR_RST &&
			expo_o == iaa_pkg::PAR_RST && bal_o == iaa_pkg::PAR_RST;
	endproperty
	a_rst: assert property (p_rst) else $error("reset value wrong");
	property p_cause;
		!$stable(gain_o) |-> $past(frame_end_i) || $past(frame_end_i, 2) ||
			$past(wr_i) || $past(wr_i, 2);
	endproperty
	a_cause: assert property (p_cause) else $error("gain moved alone");
	property p_step;
		!$stable(gain_o) && !$past(wr_i) && !$past(wr_i, 2) |->
			gain_o == $past(gain_o) + 16'h0001 ||
			gain_o == $past(gain_o) - 16'h0001;
	endproperty
	a_step: assert property (p_step) else $error("gain step wrong");
	property p_lim;
		!$stable(gain_o) && !$past(wr_i) && !$past(wr_i, 2) |->
			gain_o >= glim_r[15:0] && gain_o <= glim_r[31:16];
	endproperty
	a_lim: assert property (p_lim) else $error("gain out of limits");
	property p_seq;
		seq_r && $past(seq_r) && $past(seq_r, 2) && !wr_i |=>
			$stable(gain_o) && $stable(expo_o) && $stable(bal_o);
	endproperty
	a_seq: assert property (p_seq) else $error("moved while frozen");
	property p_off;
		goff_r && $past(goff_r) && $past(goff_r, 2) && !wr_i |=> $stable(gain_o);
	endproperty
	a_off: assert property (p_off) else $error("gain moved while off");
	property p_glim_rd;
		rd_i && addr_i == iaa_pkg::A_GLIM |=> rdata_o == glim_r;
	endproperty
	a_glim_rd: assert property (p_glim_rd) else $error("limit readback");
endmodule : iaa_ctrl_chk
`default_nettype wire

// *** test/iaa_pix_src.sv ***
// partner: binned pixel pipeline sending a small frame on request
`timescale 1ns/1ps
`default_nettype none
module iaa_pix_src (
	input wire logic mclk_i,
	input wire logic go_i,
	input wire logic [7:0] luma_i,
	input wire logic [7:0] red_i,
	input wire logic [7:0] blue_i,
	output var iaa_pkg::iaa_pix_s pix_o,
	output logic frame_end_o,
	output logic busy_o
);
	logic [2:0] cnt = 3'd0;
	logic [2:0] k;
	initial begin
		pix_o = '0;
		frame_end_o = 1'b0;
	end
	assign k = cnt - 3'd1;
	assign busy_o = cnt != 3'd0;
	// a 2x2 binned block at the origin, then the end-of-image pulse
	always @(posedge mclk_i) begin
		frame_end_o <= cnt == 3'd5;
		if (cnt >= 3'd1 && cnt <= 3'd4) begin
			pix_o <= {1'b1, 11'h0, k[0], 11'h0, k[1], luma_i, red_i, blue_i};
		end else begin
			// idle bus flips every cycle so a stale sample never looks valid
			pix_o <= {1'b0, ~pix_o[47:0]};
		end
		cnt <= go_i ? 3'd1 : (cnt == 3'd0 || cnt == 3'd6) ? 3'd0 : cnt + 3'd1;
	end
endmodule : iaa_pix_src
`default_nettype wire

// *** test/testbench.sv ***
// testbench: register and frame scenarios for the adjust controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic factory = 1'b0;
	logic go = 1'b0;
	logic [7:0] luma = 8'hF0;
	logic [31:0] rdata_o;
	logic [15:0] gain_o, expo_o, bal_o;
	logic frame_end, busy;
	iaa_pkg::iaa_pix_s pix;
	int errors = 0;
	int tests_run = 0;
	always #5 mclk_i = ~mclk_i;
	iaa_ctrl u_iaa_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.factory_start_i(factory), .frame_end_i(frame_end), .pix_i(pix),
		.gain_o(gain_o), .expo_o(expo_o), .bal_o(bal_o));
	iaa_pix_src u_iaa_pix_src (.mclk_i(mclk_i), .go_i(go), .luma_i(luma),
		.red_i(8'hA0), .blue_i(8'h60), .pix_o(pix), .frame_end_o(frame_end),
		.busy_o(busy));
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask : chk
	// gap cycle after each strobe keeps one assignment per time step
	task wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask : wr
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
		@(posedge mclk_i);
	endtask : rchk
	task gchk(input logic [15:0] exp);
		chk({16'h0000, gain_o}, {16'h0000, exp});
	endtask : gchk
	task frames(input int n);
		int k;
		repeat (n) begin
			go <= 1'b1;
			@(posedge mclk_i);
			go <= 1'b0;
			#1;
			k = 0;
			while (busy && k < 20) begin
				@(posedge mclk_i);
				#1;
				k++;
			end
			if (busy) begin
				errors++;
				report_and_stop();
			end
			repeat (2) @(posedge mclk_i);
		end
	endtask : frames
	task rst_run(input logic f);
		factory <= f;
		rst_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		factory <= 1'b0;
	endtask : rst_run
	initial begin
		rst_run(1'b1);
		rchk(iaa_pkg::A_MODE, 32'h0000_0008);
		rst_run(1'b0);
		rchk(iaa_pkg::A_MODE, 32'h0000_0000);
		rchk(iaa_pkg::A_GAIN, 32'h0000_0100);
		rchk(iaa_pkg::A_GLIM, 32'hFFFF_0000);
		rchk(iaa_pkg::A_RUSE, 32'h0000_0001);
		wr(iaa_pkg::A_RSEL, 32'h0000_0001);
		rchk(iaa_pkg::A_RUSE, 32'h0000_0002);
		rchk(iaa_pkg::A_RWID, 32'h0000_0400);
		wr(iaa_pkg::A_RSEL, 32'h0000_0000);
		rchk(8'hFC, 32'h0000_0000);
		$display("test reset finished");
		wr(iaa_pkg::A_MODE, 32'h0000_0002);
		frames(4);
		gchk(16'h0100);
		frames(1);
		gchk(16'h00FF);
		frames(2);
		gchk(16'h00FD);
		wr(iaa_pkg::A_GAIN, 32'h0000_0300);
		gchk(16'h00FD);
		wr(iaa_pkg::A_MODE, 32'h0000_0000);
		frames(2);
		gchk(16'h00FD);
		wr(iaa_pkg::A_GAIN, 32'h0000_0120);
		gchk(16'h0120);
		$display("test continuous finished");
		wr(iaa_pkg::A_GLIM, 32'hFFFF_011E);
		wr(iaa_pkg::A_MODE, 32'h0000_0002);
		frames(10);
		gchk(16'h011E);
		wr(iaa_pkg::A_MODE, 32'h0000_0000);
		wr(iaa_pkg::A_GLIM, 32'hFFFF_0000);
		wr(iaa_pkg::A_MODE, 32'h0000_0102);
		frames(8);
		gchk(16'h011E);
		$display("test limits finished");
		for (int i = 0; i < 2; i++) begin
			wr(i ? iaa_pkg::A_RXOF : iaa_pkg::A_WXOF, 32'h0000_0200);
			wr(i ? iaa_pkg::A_RWID : iaa_pkg::A_WWID, 32'h0000_0100);
			wr(iaa_pkg::A_MODE, 32'h0000_0002);
			frames(8);
			gchk(16'h011E);
			wr(iaa_pkg::A_MODE, 32'h0000_0000);
			wr(i ? iaa_pkg::A_RXOF : iaa_pkg::A_WXOF, 32'h0000_0000);
			wr(i ? iaa_pkg::A_RWID : iaa_pkg::A_WWID, 32'h0000_0400);
		end
		$display("test overlap finished");
		luma <= 8'h80;
		wr(iaa_pkg::A_MODE, 32'h0000_0001);
		frames(8);
		rchk(iaa_pkg::A_MODE, 32'h0000_0000);
		gchk(16'h011E);
		luma <= 8'hF0;
		wr(iaa_pkg::A_MODE, 32'h0000_0001);
		frames(20);
		rchk(iaa_pkg::A_MODE, 32'h0000_0001);
		frames(20);
		rchk(iaa_pkg::A_MODE, 32'h0000_0000);
		$display("test once finished");
		wr(iaa_pkg::A_GAIN, 32'h0000_0100);
		wr(iaa_pkg::A_MODE, 32'h0000_002A);
		frames(5);
		gchk(16'h00FF);
		chk({16'h0000, expo_o}, 32'h0000_00FF);
		chk({16'h0000, bal_o}, 32'h0000_00FF);
		wr(iaa_pkg::A_MODE, 32'h0000_0402);
		rchk(iaa_pkg::A_MODE, 32'h0000_0402);
		frames(1);
		gchk(16'h00FE);
		frames(1);
		gchk(16'h00FE);
		$display("test together finished");
		report_and_stop();
	end
endmodule : testbench
bind iaa_ctrl iaa_ctrl_chk u_iaa_ctrl_chk (.mclk_i(mclk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .factory_start_i(factory_start_i),
	.frame_end_i(frame_end_i), .pix_i(pix_i), .gain_o(gain_o),
	.expo_o(expo_o), .bal_o(bal_o));
`default_nettype wire
